// ==== core/hmi_pkg.sv ====
package hmi_pkg;

    // register indices
    localparam logic [7:0] OFS_CONFIG     = 8'h00;
    localparam logic [7:0] OFS_STAT_FAN   = 8'h01;
    localparam logic [7:0] OFS_STAT_VOLT  = 8'h02;
    localparam logic [7:0] OFS_STAT_TEMP  = 8'h03;
    localparam logic [7:0] OFS_SMASK_FAN  = 8'h04;
    localparam logic [7:0] OFS_SMASK_VOLT = 8'h05;
    localparam logic [7:0] OFS_SMASK_TEMP = 8'h06;
    localparam logic [7:0] OFS_IMASK_FAN  = 8'h07;
    localparam logic [7:0] OFS_IMASK_VOLT = 8'h08;
    localparam logic [7:0] OFS_IMASK_TEMP = 8'h09;
    localparam logic [7:0] OFS_IF_SEL     = 8'h0A;
    localparam logic [7:0] OFS_SMOOTH     = 8'h0B;

    // configuration fields
    localparam int CFG_INIT      = 7;
    localparam int CFG_VBAT      = 6;
    localparam int CFG_CASE_CLR  = 5;
    localparam int CFG_ONE       = 4;
    localparam int CFG_INT_CLEAR = 3;
    localparam int CFG_IRQ_EN    = 2;
    localparam int CFG_SMI_EN    = 1;
    localparam int CFG_START     = 0;

    // status / mask fields of the fan and case group and of the temperature group
    localparam int FAN5_BIT = 6;
    localparam int CASE_BIT = 4;
    localparam logic [7:0] FAN_CASE_USED = 8'h5F;
    localparam logic [7:0] TEMP_USED     = 8'h07;
    localparam int EXT_SENSOR_MASK_BIT  = 7;

    // interface select and smoothing fields
    localparam int IFS_EOC     = 7;
    localparam int IFS_SEL_LSB = 4;
    localparam int SMOOTH_LSB  = 6;

    // reset values
    localparam logic [7:0] RST_CONFIG     = 8'h18;
    localparam logic [7:0] RST_STATUS     = 8'h00;
    localparam logic [7:0] RST_MASK       = 8'h00;
    localparam logic [7:0] RST_IMASK_TEMP = 8'h80;
    localparam logic [7:0] RST_IF_SEL     = 8'h40;
    localparam logic [7:0] RST_SMOOTH     = 8'h09;

    // smoothing step rates
    localparam int CLK_HZ       = 40_000_000;
    localparam int STEP_HZ_1K   = 1000;
    localparam int STEP_HZ_256  = 256;
    localparam int STEP_HZ_64   = 64;
    localparam int STEP_HZ_16   = 16;
    localparam int STEP_CYC_1K  = CLK_HZ / STEP_HZ_1K;
    localparam int STEP_CYC_256 = CLK_HZ / STEP_HZ_256;
    localparam int STEP_CYC_64  = CLK_HZ / STEP_HZ_64;
    localparam int STEP_CYC_16  = CLK_HZ / STEP_HZ_16;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } hmi_bus_req_t;

    typedef struct packed {
        logic       fifthFan;
        logic       caseOpen;
        logic [3:0] fanFourToOne;
        logic [7:0] voltage;
        logic [2:0] temperature;
        logic       extSensor;
    } hmi_events_t;

endpackage

// ==== core/hmi_irq_control.sv ====
`timescale 1ns/1ps

// Contract
// - init bit resets registers, reads zero
// - bit 6 requests battery voltage refresh
// - writing bit 5 clears case-open latch
// - bit 4 reads one, ignores writes
// - interrupt-clear bit silences both outputs
// - bit 2 enables irq output
// - bit 1 enables system management output
// - bit 0 starts monitoring, zero standby
// - status registers clear after host read
// - fan and case events set status 1
// - voltage events set status 2 bits
// - temperature events set status 3 bits
// - mask 1 blocks fan/case from sysmgmt
// - mask 2 blocks voltage from sysmgmt
// - mask 3 blocks temperature from sysmgmt
// - irq mask 1 blocks fan/case
// - irq mask 2 blocks voltage
// - irq mask 3 blocks temperature, external sensor
// - bits 6-4 select external sensor interface
// - bits 7-6 select smoothing step rate
module hmi_irq_control
    import hmi_pkg::*;
#(
    parameter int STEP_CYCLES_1K  = STEP_CYC_1K,
    parameter int STEP_CYCLES_256 = STEP_CYC_256,
    parameter int STEP_CYCLES_64  = STEP_CYC_64,
    parameter int STEP_CYCLES_16  = STEP_CYC_16
)
(
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire hmi_bus_req_t busReq,
    output logic [7:0]        regRdData,
    input  wire hmi_events_t  events,
    output logic              sysMgmtIrq,
    output logic              irqOut,
    output logic              monitorStart,
    output logic              vbatUpdate,
    output logic              caseOpenLatch,
    output logic [2:0]        sensorIfSel,
    output logic              sensorIfActive,
    output logic              forcedEocPulse,
    output logic [1:0]        smoothRate,
    output logic              smoothStep
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    logic [7:0]  cfg;
    logic [7:0]  statFan;
    logic [7:0]  statVolt;
    logic [7:0]  statTemp;
    logic        extPending;
    logic [7:0]  smaskFan;
    logic [7:0]  smaskVolt;
    logic [7:0]  smaskTemp;
    logic [7:0]  imaskFan;
    logic [7:0]  imaskVolt;
    logic [7:0]  imaskTemp;
    logic [7:0]  ifSel;
    logic [1:0]  smooth;
    logic [21:0] stepCount;

    wire logic wr = busReq.write;
    wire logic rd = busReq.read;
    wire logic [7:0] wd = busReq.wdata;

    wire logic wrCfg   = wr && hit(busReq.addr, OFS_CONFIG);
    wire logic wrSFan  = wr && hit(busReq.addr, OFS_SMASK_FAN);
    wire logic wrSVolt = wr && hit(busReq.addr, OFS_SMASK_VOLT);
    wire logic wrSTemp = wr && hit(busReq.addr, OFS_SMASK_TEMP);
    wire logic wrIFan  = wr && hit(busReq.addr, OFS_IMASK_FAN);
    wire logic wrIVolt = wr && hit(busReq.addr, OFS_IMASK_VOLT);
    wire logic wrITemp = wr && hit(busReq.addr, OFS_IMASK_TEMP);
    wire logic wrIfSel = wr && hit(busReq.addr, OFS_IF_SEL);
    wire logic wrSmth  = wr && hit(busReq.addr, OFS_SMOOTH);
    wire logic rdFan   = rd && hit(busReq.addr, OFS_STAT_FAN);
    wire logic rdVolt  = rd && hit(busReq.addr, OFS_STAT_VOLT);
    wire logic rdTemp  = rd && hit(busReq.addr, OFS_STAT_TEMP);

    // init acts like reset for every register except regRdData, forcedEocPulse and the step divider; a one in bit 7 is never stored
    wire logic initReq = wrCfg && wd[CFG_INIT];
    wire logic clrAll  = reset || initReq;

    // config image: bit 7 and bit 5 read zero, bit 4 always one
    wire logic [7:0] cfgRead = {1'b0, cfg[CFG_VBAT], 1'b0, 1'b1,
                                cfg[3:0]};
    wire logic [7:0] next_cfg = wrCfg ? {1'b0, wd[CFG_VBAT], 1'b0, 1'b1, wd[3:0]}
                                      : cfg;

    // event vectors in register layout
    wire logic [7:0] fanEv  = {1'b0, events.fifthFan, 1'b0, events.caseOpen,
                               events.fanFourToOne};
    wire logic [7:0] voltEv = events.voltage;
    wire logic [7:0] tempEv = {5'h00, events.temperature};

    // set wins over the read clear so a coincident event is kept
    wire logic [7:0] next_statFan  = (rdFan  ? 8'h00 : statFan)  | fanEv;
    wire logic [7:0] next_statVolt = (rdVolt ? 8'h00 : statVolt) | voltEv;
    wire logic [7:0] next_statTemp = (rdTemp ? 8'h00 : statTemp) | tempEv;
    wire logic next_extPending = (rdTemp ? 1'b0 : extPending) | events.extSensor;

    wire logic next_caseLatch = (caseOpenLatch && !(wrCfg && wd[CFG_CASE_CLR]))
                                || events.caseOpen;

    // unmasked pending per output
    wire logic smiAny = |(statFan & FAN_CASE_USED & ~smaskFan)
                     || |(statVolt & ~smaskVolt)
                     || |(statTemp & TEMP_USED & ~smaskTemp);
    wire logic irqAny = |(statFan & FAN_CASE_USED & ~imaskFan)
                     || |(statVolt & ~imaskVolt)
                     || |(statTemp & TEMP_USED & ~imaskTemp)
                     || (extPending && !imaskTemp[EXT_SENSOR_MASK_BIT]);
    wire logic next_smi = cfg[CFG_SMI_EN] && !cfg[CFG_INT_CLEAR] && smiAny;
    wire logic next_irq = cfg[CFG_IRQ_EN] && !cfg[CFG_INT_CLEAR] && irqAny;

    // forced end of conversion fires when the host drops the bit it raised
    wire logic next_eoc = wrIfSel && ifSel[IFS_EOC] && !wd[IFS_EOC];
    wire logic [7:0] next_ifSel = wrIfSel ? {wd[7:4], 4'h0} : ifSel;
    wire logic [2:0] selField = next_ifSel[IFS_SEL_LSB +: 3];

    // read mux, unmapped indices read zero
    logic [7:0] rdMux;
    always_comb
    begin
        if (hit(busReq.addr, OFS_CONFIG))          rdMux = cfgRead;
        else if (hit(busReq.addr, OFS_STAT_FAN))   rdMux = statFan & FAN_CASE_USED;
        else if (hit(busReq.addr, OFS_STAT_VOLT))  rdMux = statVolt;
        else if (hit(busReq.addr, OFS_STAT_TEMP))  rdMux = statTemp & TEMP_USED;
        else if (hit(busReq.addr, OFS_SMASK_FAN))  rdMux = smaskFan;
        else if (hit(busReq.addr, OFS_SMASK_VOLT)) rdMux = smaskVolt;
        else if (hit(busReq.addr, OFS_SMASK_TEMP)) rdMux = smaskTemp;
        else if (hit(busReq.addr, OFS_IMASK_FAN))  rdMux = imaskFan;
        else if (hit(busReq.addr, OFS_IMASK_VOLT)) rdMux = imaskVolt;
        else if (hit(busReq.addr, OFS_IMASK_TEMP)) rdMux = imaskTemp;
        else if (hit(busReq.addr, OFS_IF_SEL))     rdMux = ifSel;
        else if (hit(busReq.addr, OFS_SMOOTH))     rdMux = {smooth, RST_SMOOTH[5:0]};
        else                                       rdMux = 8'h00;
    end

    // smoothing step divider; period follows the selected rate
    logic [21:0] stepLimit;
    always_comb
    begin
        case (smooth)
            2'b00:   stepLimit = 22'(STEP_CYCLES_1K - 1);
            2'b01:   stepLimit = 22'(STEP_CYCLES_256 - 1);
            2'b10:   stepLimit = 22'(STEP_CYCLES_64 - 1);
            default: stepLimit = 22'(STEP_CYCLES_16 - 1);
        endcase
    end
    // a rate change restarts the count so a shorter period never waits a long one out
    wire logic stepWrap = (stepCount >= stepLimit) || wrSmth;

    always_ff @(posedge clk_sys)
    begin
        regRdData <= rd ? rdMux : 8'h00;
        forcedEocPulse <= reset ? 1'b0 : next_eoc;
        smoothStep <= reset ? 1'b0 : (stepCount >= stepLimit);
        stepCount <= (reset || stepWrap) ? 22'h000000 : stepCount + 22'h000001;
    end

    // every register from here on takes the same clear, so init and reset can never disagree on them
    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            cfg <= RST_CONFIG;
        end
        else
        begin
            cfg <= next_cfg;
        end
    end

    // status keeps collecting while the outputs are silenced
    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            statFan <= RST_STATUS;
        end
        else
        begin
            statFan <= next_statFan;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            statVolt <= RST_STATUS;
        end
        else
        begin
            statVolt <= next_statVolt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            statTemp <= RST_STATUS;
        end
        else
        begin
            statTemp <= next_statTemp;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            extPending <= 1'b0;
        end
        else
        begin
            extPending <= next_extPending;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            smaskFan <= RST_MASK;
        end
        else if (wrSFan)
        begin
            smaskFan <= wd;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            smaskVolt <= RST_MASK;
        end
        else if (wrSVolt)
        begin
            smaskVolt <= wd;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            smaskTemp <= RST_MASK;
        end
        else if (wrSTemp)
        begin
            smaskTemp <= wd;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            imaskFan <= RST_MASK;
        end
        else if (wrIFan)
        begin
            imaskFan <= wd;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            imaskVolt <= RST_MASK;
        end
        else if (wrIVolt)
        begin
            imaskVolt <= wd;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            imaskTemp <= RST_IMASK_TEMP;
        end
        else if (wrITemp)
        begin
            imaskTemp <= wd;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            ifSel <= RST_IF_SEL;
        end
        else
        begin
            ifSel <= next_ifSel;
        end
    end

    // the rate output is a copy of the stored field so it leaves a flip-flop
    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            smooth     <= RST_SMOOTH[SMOOTH_LSB +: 2];
            smoothRate <= RST_SMOOTH[SMOOTH_LSB +: 2];
        end
        else if (wrSmth)
        begin
            smooth     <= wd[SMOOTH_LSB +: 2];
            smoothRate <= wd[SMOOTH_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            caseOpenLatch <= 1'b0;
        end
        else
        begin
            caseOpenLatch <= next_caseLatch;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            sysMgmtIrq <= 1'b0;
            irqOut     <= 1'b0;
        end
        else
        begin
            sysMgmtIrq <= next_smi;
            irqOut     <= next_irq;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            monitorStart <= RST_CONFIG[CFG_START];
            vbatUpdate   <= RST_CONFIG[CFG_VBAT];
        end
        else
        begin
            monitorStart <= next_cfg[CFG_START];
            vbatUpdate   <= next_cfg[CFG_VBAT];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clrAll)
        begin
            sensorIfSel    <= RST_IF_SEL[IFS_SEL_LSB +: 3];
            sensorIfActive <= RST_IF_SEL[IFS_SEL_LSB + 2];
        end
        else
        begin
            sensorIfSel    <= selField;
            // only the 1xx codes name a protocol; 000 and reserved codes stay idle
            sensorIfActive <= selField[2];
        end
    end

endmodule

// ==== dv/hmi_irq_control_chk.sv ====
`timescale 1ns/1ps
module hmi_irq_control_chk
    import hmi_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         reset,
    input wire hmi_bus_req_t busReq,
    input wire logic [7:0]   regRdData,
    input wire hmi_events_t  events,
    input wire logic         sysMgmtIrq,
    input wire logic         irqOut,
    input wire logic         monitorStart,
    input wire logic         caseOpenLatch,
    input wire logic [2:0]   sensorIfSel
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    wire cfgWr = busReq.write && busReq.addr == OFS_CONFIG;
    wire rdVolt = busReq.read && busReq.addr == OFS_STAT_VOLT;
    property p_cfgRead;
        busReq.read && busReq.addr == OFS_CONFIG |=> regRdData[CFG_ONE] && !regRdData[CFG_INIT];
    endproperty
    a_cfgRead: assert property (p_cfgRead) else $error("config bits 7/4 wrong");
    property p_rdClr;
        rdVolt && events.voltage == 8'h00 ##1 rdVolt |=> regRdData == 8'h00;
    endproperty
    a_rdClr: assert property (p_rdClr) else $error("status not cleared by read");
    property p_intClr;
        cfgWr && busReq.wdata[CFG_INT_CLEAR] |-> ##2 !sysMgmtIrq && !irqOut;
    endproperty
    a_intClr: assert property (p_intClr) else $error("output active under clear");
    property p_irqEn;
        cfgWr && !busReq.wdata[CFG_IRQ_EN] |-> ##2 !irqOut;
    endproperty
    a_irqEn: assert property (p_irqEn) else $error("irq active while disabled");
    property p_smiEn;
        cfgWr && !busReq.wdata[CFG_SMI_EN] |-> ##2 !sysMgmtIrq;
    endproperty
    a_smiEn: assert property (p_smiEn) else $error("sysmgmt active while off");
    property p_start;
        cfgWr |=> monitorStart == ($past(busReq.wdata[CFG_START])
                                  && !$past(busReq.wdata[CFG_INIT]));
    endproperty
    a_start: assert property (p_start) else $error("start level wrong");
    property p_caseClr;
        cfgWr && busReq.wdata[CFG_CASE_CLR] && !events.caseOpen |=> !caseOpenLatch;
    endproperty
    a_caseClr: assert property (p_caseClr) else $error("case latch not cleared");
    property p_caseSet;
        events.caseOpen |=> caseOpenLatch;
    endproperty
    a_caseSet: assert property (p_caseSet) else $error("case latch not set");
    property p_ifSel;
        busReq.write && busReq.addr == OFS_IF_SEL |=> sensorIfSel == $past(busReq.wdata[6:4]);
    endproperty
    a_ifSel: assert property (p_ifSel) else $error("interface select wrong");
    c_smi: cover property (sysMgmtIrq);
    c_irq: cover property (irqOut);
    c_case: cover property (caseOpenLatch);
endmodule

bind hmi_irq_control hmi_irq_control_chk u_chk (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .busReq        (busReq),
    .regRdData     (regRdData),
    .events        (events),
    .sysMgmtIrq    (sysMgmtIrq),
    .irqOut        (irqOut),
    .monitorStart  (monitorStart),
    .caseOpenLatch (caseOpenLatch),
    .sensorIfSel   (sensorIfSel)
);

// ==== dv/hmi_host_model.sv ====
`timescale 1ns/1ps
module hmi_host_model
    import hmi_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] regRdData,
    output hmi_bus_req_t    busReq
);
    initial busReq = '0;
    // idle cycle after the strobe so back-to-back calls never drive twice at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        busReq.write <= 1'b0;
        @(posedge clk_sys);
    endtask
    // two reads back to back; data sampled before the edge's own update lands
    task automatic rd(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        @(posedge clk_sys);
        d0 = regRdData;
        busReq.read <= 1'b0;
        @(posedge clk_sys);
        d1 = regRdData;
    endtask
    task automatic eoc(input logic [2:0] sel);
        wr(OFS_IF_SEL, {1'b1, sel, 4'h0});
        wr(OFS_IF_SEL, {1'b0, sel, 4'h0});
    endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import hmi_pkg::*;
;
    logic         clk_sys = 1'b0;
    logic         reset = 1'b1;
    hmi_bus_req_t busReq;
    hmi_events_t  events = '0;
    logic [7:0]   regRdData;
    logic [7:0]   d0;
    logic [7:0]   d1;
    logic         smi;
    logic         irq;
    logic         start;
    logic         caseL;
    logic         eocP;
    logic [2:0]   ifSel;
    logic         vbat;
    logic         ifAct;
    logic [1:0]   rate;
    logic         step;
    localparam int SIM_CYC = 10;
    int           err_total = 0;
    int           n_compared = 0;
    int           cycles = 0;
    logic [7:0]   rstv [13] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h80, 8'h40, 8'h09, 8'h00};
    always #12.5 clk_sys = ~clk_sys;
    hmi_irq_control #(.STEP_CYCLES_1K(SIM_CYC), .STEP_CYCLES_256(SIM_CYC * 2),
        .STEP_CYCLES_64(SIM_CYC * 4), .STEP_CYCLES_16(SIM_CYC * 8)) u_hmi_irq_control (
        .clk_sys(clk_sys), .reset(reset),
        .busReq(busReq), .regRdData(regRdData), .events(events), .sysMgmtIrq(smi),
        .irqOut(irq), .monitorStart(start), .vbatUpdate(vbat), .caseOpenLatch(caseL),
        .sensorIfSel(ifSel), .sensorIfActive(ifAct), .forcedEocPulse(eocP),
        .smoothRate(rate), .smoothStep(step));
    hmi_host_model u_hmi_host_model (.clk_sys(clk_sys), .regRdData(regRdData), .busReq(busReq));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // events pulse one cycle; outputs lag two edges, so wait one more
    task automatic ev(input hmi_events_t e);
        events <= e;
        @(posedge clk_sys);
        events <= '0;
        @(posedge clk_sys);
        @(posedge clk_sys);
    endtask
    task automatic t_defaults;
        for (int i = 0; i < 13; i++)
        begin
            u_hmi_host_model.rd(i[7:0], d0, d1);
            chk("reg", d0, rstv[i]);
        end
    endtask
    task automatic t_rw;
        for (int i = 4; i < 10; i++)
            u_hmi_host_model.wr(i[7:0], 8'hFF);
        u_hmi_host_model.wr(OFS_SMOOTH, 8'hFF);
        u_hmi_host_model.wr(OFS_IF_SEL, 8'h70);
        u_hmi_host_model.wr(OFS_STAT_FAN, 8'hFF);
        for (int i = 4; i < 10; i++)
        begin
            u_hmi_host_model.rd(i[7:0], d0, d1);
            chk("mask", d0, 8'hFF);
        end
        u_hmi_host_model.rd(OFS_SMOOTH, d0, d1);
        chk("smooth", d0, 8'hC9);
        u_hmi_host_model.rd(OFS_IF_SEL, d0, d1);
        chk("ifsel", d0, 8'h70);
        u_hmi_host_model.rd(OFS_STAT_FAN, d0, d1);
        chk("stat1 wr", d0, 8'h00);
        u_hmi_host_model.wr(OFS_CONFIG, 8'h80);
    endtask
    task automatic t_stat;
        ev('{1'b1, 1'b1, 4'hF, 8'hA5, 3'h7, 1'b0});
        chk("case", {7'h0, caseL}, 8'h01);
        u_hmi_host_model.rd(OFS_STAT_FAN, d0, d1);
        chk("stat1", d0, 8'h5F);
        chk("stat1 clr", d1, 8'h00);
        u_hmi_host_model.rd(OFS_STAT_VOLT, d0, d1);
        chk("stat2", d0, 8'hA5);
        u_hmi_host_model.rd(OFS_STAT_TEMP, d0, d1);
        chk("stat3", d0, 8'h07);
        chk("stat3 clr", d1, 8'h00);
        u_hmi_host_model.wr(OFS_CONFIG, 8'h20);
        chk("case clr", {7'h0, caseL}, 8'h00);
    endtask
    task automatic t_irq;
        u_hmi_host_model.wr(OFS_CONFIG, 8'h03);
        chk("start", {7'h0, start}, 8'h01);
        ev('{1'b0, 1'b0, 4'h0, 8'h01, 3'h0, 1'b0});
        chk("smi", {7'h0, smi}, 8'h01);
        chk("irq off", {7'h0, irq}, 8'h00);
        u_hmi_host_model.wr(OFS_SMASK_VOLT, 8'h01);
        u_hmi_host_model.rd(OFS_STAT_VOLT, d0, d1);
        ev('{1'b0, 1'b0, 4'h0, 8'h01, 3'h0, 1'b0});
        chk("smi masked", {7'h0, smi}, 8'h00);
        ev('{1'b0, 1'b0, 4'h0, 8'h02, 3'h0, 1'b0});
        chk("smi", {7'h0, smi}, 8'h01);
        u_hmi_host_model.wr(OFS_CONFIG, 8'h0B);
        @(posedge clk_sys);
        chk("smi clr", {7'h0, smi}, 8'h00);
        u_hmi_host_model.rd(OFS_STAT_VOLT, d0, d1);
        chk("stat kept", d0, 8'h03);
        u_hmi_host_model.wr(OFS_CONFIG, 8'h05);
        ev('{1'b0, 1'b0, 4'h0, 8'h00, 3'h1, 1'b0});
        chk("irq", {7'h0, irq}, 8'h01);
        chk("smi off", {7'h0, smi}, 8'h00);
        u_hmi_host_model.wr(OFS_IMASK_TEMP, 8'h81);
        @(posedge clk_sys);
        chk("irq masked", {7'h0, irq}, 8'h00);
        u_hmi_host_model.eoc(3'b101);
        chk("eoc", {7'h0, eocP}, 8'h01);
        chk("sel", {5'h0, ifSel}, 8'h05);
        chk("if active", {7'h0, ifAct}, 8'h01);
        @(posedge clk_sys);
        chk("eoc end", {7'h0, eocP}, 8'h00);
    endtask
    task automatic t_mask;
        u_hmi_host_model.rd(OFS_STAT_TEMP, d0, d1);
        chk("stat3 kept", d0, 8'h01);
        u_hmi_host_model.wr(OFS_SMASK_FAN, 8'h10);
        u_hmi_host_model.wr(OFS_IMASK_FAN, 8'h40);
        u_hmi_host_model.wr(OFS_SMASK_TEMP, 8'h02);
        u_hmi_host_model.wr(OFS_IMASK_VOLT, 8'h04);
        u_hmi_host_model.wr(OFS_CONFIG, 8'h07);
        ev('{1'b0, 1'b1, 4'h0, 8'h00, 3'h0, 1'b0});
        chk("smi case", {7'h0, smi}, 8'h00);
        chk("irq case", {7'h0, irq}, 8'h01);
        u_hmi_host_model.rd(OFS_STAT_FAN, d0, d1);
        ev('{1'b1, 1'b0, 4'h0, 8'h00, 3'h0, 1'b0});
        chk("smi fan5", {7'h0, smi}, 8'h01);
        chk("irq fan5", {7'h0, irq}, 8'h00);
        u_hmi_host_model.rd(OFS_STAT_FAN, d0, d1);
        ev('{1'b0, 1'b0, 4'h0, 8'h00, 3'h2, 1'b0});
        chk("smi temp", {7'h0, smi}, 8'h00);
        chk("irq temp", {7'h0, irq}, 8'h01);
        u_hmi_host_model.rd(OFS_STAT_TEMP, d0, d1);
        ev('{1'b0, 1'b0, 4'h0, 8'h04, 3'h0, 1'b0});
        chk("smi volt", {7'h0, smi}, 8'h01);
        chk("irq volt", {7'h0, irq}, 8'h00);
        u_hmi_host_model.rd(OFS_STAT_VOLT, d0, d1);
        ev('{1'b0, 1'b0, 4'h0, 8'h00, 3'h0, 1'b1});
        chk("irq ext", {7'h0, irq}, 8'h00);
        u_hmi_host_model.wr(OFS_IMASK_TEMP, 8'h01);
        @(posedge clk_sys);
        chk("irq ext on", {7'h0, irq}, 8'h01);
        u_hmi_host_model.rd(OFS_STAT_TEMP, d0, d1);
        chk("irq ext clr", {7'h0, irq}, 8'h00);
    endtask
    // the first sample after a rate write is skipped: it may carry the old period's pulse
    task automatic t_cfg;
        int n;
        u_hmi_host_model.wr(OFS_CONFIG, 8'h41);
        chk("vbat", {7'h0, vbat}, 8'h01);
        u_hmi_host_model.rd(OFS_CONFIG, d0, d1);
        chk("cfg vbat", d0, 8'h51);
        u_hmi_host_model.wr(OFS_IF_SEL, 8'h20);
        chk("sel rsvd", {4'h0, ifAct, ifSel}, 8'h02);
        for (int r = 0; r < 4; r++)
        begin
            u_hmi_host_model.wr(OFS_SMOOTH, 8'(r << 6));
            chk("rate", {6'h0, rate}, 8'(r));
            @(posedge clk_sys);
            while (!step) @(posedge clk_sys);
            n = 0;
            do
            begin
                @(posedge clk_sys);
                n++;
            end
            while (!step);
            chk("step", 8'(n), 8'(SIM_CYC << r));
        end
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            finish_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_defaults();
        t_rw();
        t_defaults();
        t_stat();
        t_irq();
        t_mask();
        t_cfg();
        finish_test();
    end
endmodule
